// ===== atc_pkg.sv
// package: register map, field layout and timing constants for the converter timing control
package atc_pkg;

  // ==========================================================================
  // register map
  localparam logic [3:0]  CTRL0_OFFSET     = 4'h0;   // converter_control_0 byte address
  localparam logic [3:0]  STATUS_OFFSET    = 4'h4;   // conversion status
  localparam logic [3:0]  RESULT_OFFSET    = 4'h8;   // last conversion result
  localparam logic [3:0]  START_OFFSET     = 4'hC;   // write any value to start
  localparam logic [15:0] CTRL0_RESET      = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;

  // ==========================================================================
  // field positions inside converter_control_0
  localparam int DIV_SEL_LSB   = 0;
  localparam int DIV_SEL_W     = 5;
  localparam int FINAL_SEL_LSB = 5;
  localparam int FINAL_SEL_W   = 2;
  localparam int RES_BIT = 7;
  localparam logic [15:0] CTRL0_USED_MASK = 16'h00FF;

  // ==========================================================================
  // phase lengths in converter clock periods
  localparam logic [4:0] INIT_SAMPLE_CLKS = 5'h02;
  localparam logic [4:0] TRANSFER_CLKS    = 5'h02;
  localparam logic [4:0] RESOLVE8_CLKS    = 5'h0A;
  localparam logic [4:0] RESOLVE10_CLKS   = 5'h0C;
  localparam logic [4:0] FINAL_SAMPLE_00  = 5'h02;
  localparam logic [4:0] FINAL_SAMPLE_01  = 5'h04;
  localparam logic [4:0] FINAL_SAMPLE_10  = 5'h08;
  localparam logic [4:0] FINAL_SAMPLE_11  = 5'h10;

  // ==========================================================================
  // types
  typedef enum {PH_IDLE, PH_INIT, PH_XFER, PH_FINAL, PH_RESOLVE} atc_phase_t;

  typedef struct packed {
    logic       resolution_select;
    logic [1:0] final_sample_select;
    logic [4:0] clock_divider_select;
  } atc_cfg_t;

  typedef struct packed {
    logic       start;
    logic [9:0] data;
    logic       data_valid;
  } atc_core_in_t;

endpackage

// ===== atc_prescaler.sv
// two-stage prescaler: programmable modulus counter then divide-by-two
`timescale 1ns/1ps
`default_nettype none
module atc_prescaler #(
  parameter int          CODE_W = 5,
  // offset added to the code to give the first-stage divide ratio minus one; default ratio = code + 2, capped at 32
  parameter logic [31:0] RATIO_OFFSET = 32'h0000_0001
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire logic [CODE_W-1:0] code_i,
  output logic                   tick_o
);

  typedef struct packed {
    logic [CODE_W:0] cnt;
    logic            half;
    logic            tick;
  } atc_ps_state_t;

  atc_ps_state_t state_reg;
  atc_ps_state_t state_next;

  // ==========================================================================
  // configurable code-to-terminal-count lookup
  // largest terminal count: first stage never divides by more than 2**CODE_W
  localparam logic [CODE_W:0] TERM_MAX = {1'b0, {CODE_W{1'b1}}};

  // R12: configurable ratio lookup
  function automatic logic [CODE_W:0] term_count(input logic [CODE_W-1:0] c);
    logic [CODE_W+1:0] sum;
    sum        = {2'b00, c} + RATIO_OFFSET[CODE_W+1:0];
    term_count = (sum > {1'b0, TERM_MAX}) ? TERM_MAX : sum[CODE_W:0];
  endfunction

  // ==========================================================================
  // no reload on code change: the >= compare ends the count at once if a smaller limit was passed
  // R10: modulus counter stage
  always_comb begin
    state_next      = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.cnt >= term_count(code_i)) begin
      state_next.cnt  = '0;
      // R11: halving second stage
      state_next.half = ~state_reg.half; // second stage halves
      state_next.tick = state_reg.half;  // one pulse per converter clock
    end else begin
      state_next.cnt = state_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick_o = state_reg.tick;

endmodule
`default_nettype wire

// ===== atc_top.sv
// converter timing control: register slave, prescaler and conversion phase sequencer
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: resolution bit clear gives 8-bit conversion, set gives 10-bit.
// R2: control register writes change all settings immediately.
// R3: result alignment follows selected resolution.
// R4: conversion runs initial sample, transfer, final sample, resolution in order.
// R5: initial sample lasts two converter clocks.
// R6: transfer lasts two converter clocks.
// R7: resolution lasts ten clocks for 8-bit, twelve for 10-bit.
// R8: final sample code 00/01/10/11 gives 2/4/8/16 converter clocks.
// R9: converter clock comes from system clock through two prescaler stages.
// R10: first stage is 5-bit modulus counter, ratio two to 32.
// R11: second stage halves first stage output.
// R12: code-to-ratio mapping is a configurable lookup.
module atc_top #(
  parameter logic [31:0] RATIO_OFFSET = 32'h0000_0001
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [9:0]  core_data_i,
  output logic             conv_clk_tick_o,
  output logic             core_sample_o,
  output logic             core_transfer_o,
  output logic             core_resolve_o,
  output logic             core_ten_bit_o,
  output logic             busy_o
);

  typedef struct packed {
    logic [15:0]        ctrl;
    atc_pkg::atc_phase_t phase;
    logic [4:0]         left;
    logic [15:0]        result;
    logic               done;
    logic               ack;
    logic [31:0]        rdata;
    logic               tick;
    logic               sample;
    logic               transfer;
    logic               resolve;
    logic               busy;
    logic               wait_req;
  } atc_state_t;

  atc_state_t state_reg;
  atc_state_t state_next;
  atc_pkg::atc_cfg_t cfg;
  logic tick;

  // ==========================================================================
  // live config: every field used directly from the register
  // R2: immediate effect
  assign cfg.resolution_select    = state_reg.ctrl[atc_pkg::RES_BIT];
  assign cfg.final_sample_select  = state_reg.ctrl[atc_pkg::FINAL_SEL_LSB +: atc_pkg::FINAL_SEL_W];
  assign cfg.clock_divider_select = state_reg.ctrl[atc_pkg::DIV_SEL_LSB +: atc_pkg::DIV_SEL_W];

  // ==========================================================================
  // prescaler
  // R9: two-stage prescaler instance
  atc_prescaler #(
    .CODE_W       (atc_pkg::DIV_SEL_W),
    .RATIO_OFFSET (RATIO_OFFSET)
  ) u_prescaler (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .code_i    (cfg.clock_divider_select),
    .tick_o    (tick)
  );

  // R8: final sample lookup
  function automatic logic [4:0] final_len(input logic [1:0] sel);
    unique case (sel)
      2'b00: final_len = atc_pkg::FINAL_SAMPLE_00;
      2'b01: final_len = atc_pkg::FINAL_SAMPLE_01;
      2'b10: final_len = atc_pkg::FINAL_SAMPLE_10;
      2'b11: final_len = atc_pkg::FINAL_SAMPLE_11;
    endcase
  endfunction

  // R7: resolution length by width
  function automatic logic [4:0] resolve_len(input logic ten);
    resolve_len = ten ? atc_pkg::RESOLVE10_CLKS : atc_pkg::RESOLVE8_CLKS;
  endfunction

  logic wr_hit;
  logic rd_hit;
  assign wr_hit = avs_write_i && !state_reg.ack;
  assign rd_hit = avs_read_i && !state_reg.ack;

  // ==========================================================================
  // bus slave, sequencer and result capture
  always_comb begin
    state_next       = state_reg;
    state_next.ack   = 1'b0;
    state_next.tick  = tick;
    // one wait cycle per access, answered next edge
    if (wr_hit || rd_hit) begin
      state_next.ack = 1'b1;
    end
    if (wr_hit && avs_address_i == atc_pkg::CTRL0_OFFSET) begin
      if (avs_byteenable_i[0]) begin
        state_next.ctrl[7:0] = avs_writedata_i[7:0] & atc_pkg::CTRL0_USED_MASK[7:0];
      end
    end
    if (rd_hit) begin
      unique case (avs_address_i)
        atc_pkg::CTRL0_OFFSET:  state_next.rdata = {16'h0000, state_reg.ctrl};
        atc_pkg::STATUS_OFFSET: state_next.rdata = {30'h0000_0000, state_reg.done,
                                                    state_reg.phase != atc_pkg::PH_IDLE};
        atc_pkg::RESULT_OFFSET: state_next.rdata = {16'h0000, state_reg.result};
        default:                state_next.rdata = atc_pkg::UNMAPPED_READ;
      endcase
    end
    // R4: phase sequence advanced on converter clock ticks
    if (state_reg.phase == atc_pkg::PH_IDLE) begin
      if (wr_hit && avs_address_i == atc_pkg::START_OFFSET) begin
        state_next.phase = atc_pkg::PH_INIT;
        state_next.left  = atc_pkg::INIT_SAMPLE_CLKS; // R5: two clocks
        state_next.done  = 1'b0;
      end
    end else if (tick) begin
      if (state_reg.left > 5'h01) begin
        state_next.left = state_reg.left - 5'h01;
      end else begin
        unique case (state_reg.phase)
          atc_pkg::PH_INIT: begin
            state_next.phase = atc_pkg::PH_XFER;
            state_next.left  = atc_pkg::TRANSFER_CLKS; // R6: two clocks
          end
          atc_pkg::PH_XFER: begin
            state_next.phase = atc_pkg::PH_FINAL;
            state_next.left  = final_len(cfg.final_sample_select);
          end
          atc_pkg::PH_FINAL: begin
            state_next.phase = atc_pkg::PH_RESOLVE;
            state_next.left  = resolve_len(cfg.resolution_select);
          end
          default: begin
            state_next.phase = atc_pkg::PH_IDLE;
            state_next.left  = '0;
            state_next.done  = 1'b1;
            // R3: R1: 10-bit right aligned, 8-bit takes upper eight bits
            state_next.result = cfg.resolution_select ? {6'h00, core_data_i}
                                                      : {8'h00, core_data_i[9:2]};
          end
        endcase
      end
    end
    // reading status clears done unless a conversion completes now
    if (rd_hit && avs_address_i == atc_pkg::STATUS_OFFSET && state_next.done == state_reg.done) begin
      state_next.done = 1'b0;
    end
    // port flops follow the next phase so they switch on the same edge as it
    state_next.sample   = (state_next.phase == atc_pkg::PH_INIT) || (state_next.phase == atc_pkg::PH_FINAL);
    state_next.transfer = state_next.phase == atc_pkg::PH_XFER;
    state_next.resolve  = state_next.phase == atc_pkg::PH_RESOLVE;
    state_next.busy     = state_next.phase != atc_pkg::PH_IDLE;
    state_next.wait_req = !state_next.ack;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg       <= '0;
      state_reg.ctrl  <= atc_pkg::CTRL0_RESET;
      state_reg.phase <= atc_pkg::PH_IDLE;
      state_reg.wait_req <= 1'b1; // bus stalled while in reset
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // outputs straight from state flops
  assign avs_readdata_o    = state_reg.rdata;
  assign avs_waitrequest_o = state_reg.wait_req;
  assign conv_clk_tick_o   = state_reg.tick;
  assign core_sample_o     = state_reg.sample;
  assign core_transfer_o   = state_reg.transfer;
  assign core_resolve_o    = state_reg.resolve;
  assign core_ten_bit_o    = state_reg.ctrl[atc_pkg::RES_BIT];
  assign busy_o            = state_reg.busy;

endmodule
`default_nettype wire

// ===== atc_core_model.sv
// far-side model of the analog sample-and-convert core
`timescale 1ns/1ps
`default_nettype none
module atc_core_model #(
  parameter logic [9:0] VALUE = 10'h2D6
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic       core_resolve_i,
  output logic [9:0]      core_data_o
);
  // =====================================================================
  // data lines
  // result is driven while resolving; elsewhere the lines toggle between the value and its inverse, so data taken there is wrong every other cycle
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) core_data_o <= ~VALUE;
    else if (core_resolve_i) core_data_o <= VALUE;
    else core_data_o <= ~core_data_o;
  end
endmodule
`default_nettype wire

// ===== atc_top_props.sv
// concurrent checks on the converter timing control ports
`timescale 1ns/1ps
`default_nettype none
module atc_top_chk #(
  parameter logic [31:0] RATIO_OFFSET = 32'h0000_0001
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_readdata_o,
  input  wire logic        avs_waitrequest_o,
  input  wire logic [9:0]  core_data_i,
  input  wire logic        conv_clk_tick_o,
  input  wire logic        core_sample_o,
  input  wire logic        core_transfer_o,
  input  wire logic        core_resolve_o,
  input  wire logic        core_ten_bit_o,
  input  wire logic        busy_o
);
  // =====================================================================
  // properties
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  chk_wait_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  chk_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("access not answered after one wait cycle");
  chk_phase_excl: assert property ($onehot0({core_sample_o, core_transfer_o, core_resolve_o}))
    else $error("two conversion phases active together");
  chk_busy_cover: assert property (core_sample_o || core_transfer_o || core_resolve_o |-> busy_o)
    else $error("phase active while not busy");
  chk_tick_gap: assert property (conv_clk_tick_o |=> !conv_clk_tick_o [*3])
    else $error("converter ticks closer than four cycles");
  chk_res_write: assert property ($changed(core_ten_bit_o) |-> $past(avs_write_i))
    else $error("resolution changed without a write");
  chk_xfer_order: assert property ($rose(core_transfer_o) |-> $past(core_sample_o))
    else $error("transfer not preceded by sampling");
  chk_resolve_order: assert property ($rose(core_resolve_o) |-> $past(core_sample_o))
    else $error("resolution not preceded by final sample");
endmodule
bind atc_top atc_top_chk #(.RATIO_OFFSET(RATIO_OFFSET)) i_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .core_data_i(core_data_i), .conv_clk_tick_o(conv_clk_tick_o),
  .core_sample_o(core_sample_o), .core_transfer_o(core_transfer_o), .core_resolve_o(core_resolve_o),
  .core_ten_bit_o(core_ten_bit_o), .busy_o(busy_o));
`default_nettype wire

// ===== tb_top.sv
// testbench: register access and conversion phase timing
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [9:0] VAL = 10'h2D6;
  logic        clk_sys_i, rstn_i, rd_i, wr_i, tick, smp, xfr, rsv, ten, busy, wt;
  logic [3:0]  adr, be;
  logic [31:0] wd, rdata, q;
  logic [9:0]  cdata;
  logic [2:0]  ph, ph_q;
  int          fails, checked, tk, gap, since, seg[$];

  atc_top i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_address_i(adr), .avs_read_i(rd_i),
    .avs_write_i(wr_i), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wt), .core_data_i(cdata), .conv_clk_tick_o(tick), .core_sample_o(smp),
    .core_transfer_o(xfr), .core_resolve_o(rsv), .core_ten_bit_o(ten), .busy_o(busy));
  atc_core_model #(.VALUE(VAL)) i_core (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .core_resolve_i(rsv),
    .core_data_o(cdata));

  // =====================================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one bus access; entered just after a rising edge, answer taken at the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    adr <= a;
    wr_i <= w;
    rd_i <= !w;
    wd <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys_i);
      if (wt === 1'b0) break;
    end
    q = rdata;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    if (n == 50) stop_test(1'b1);
    // one idle edge so the next call never re-raises a strobe in this time step
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  task automatic stop_test(input bit timed_out);
    if (timed_out) fails++;
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one conversion, with a second start mid-run that must be ignored
  task automatic conv(input logic res, input logic [1:0] fsel, input logic [4:0] code);
    int n;
    bus(1'b1, atc_pkg::CTRL0_OFFSET, {24'h00_0000, res, fsel, code});
    chk({31'h0, ten}, {31'h0, res});
    seg.delete();
    bus(1'b1, atc_pkg::START_OFFSET, 32'h0000_0000);
    bus(1'b1, atc_pkg::START_OFFSET, 32'h0000_0000);
    for (n = 0; n < 5000 && busy !== 1'b0; n++) @(negedge clk_sys_i);
    if (n == 5000) stop_test(1'b1);
    @(posedge clk_sys_i);
    rd(atc_pkg::RESULT_OFFSET, res ? {22'h00_0000, VAL} : {24'h00_0000, VAL[9:2]});
    rd(atc_pkg::STATUS_OFFSET, 32'h0000_0002);
    rd(atc_pkg::STATUS_OFFSET, 32'h0000_0000);
    chk(seg.size(), 4);
    chk(seg[0], 102);
    chk(seg[1], 202);
    chk(seg[2], 100 + (2 << fsel));
    chk(seg[3], res ? 412 : 410);
    chk(gap, 2 * ((code > 5'h1E) ? 32 : code + 2));
    $display("conversion res %0d final %0d code %0d done", res, fsel, code);
  endtask

  // =====================================================================
  // phase lengths in ticks, coded as phase*100+ticks; gap is sysclk cycles per tick
  // a tick reaches the port one cycle after the sequencer used it, so it counts for the previous phase
  always @(posedge clk_sys_i) begin
    ph = {rsv, xfr, smp};
    if (tick === 1'b1) begin
      tk += (ph_q != 3'h0);
      gap = since;
      since = 1;
    end else since++;
    if (ph != ph_q && ph_q != 3'h0) seg.push_back(ph_q * 100 + tk);
    if (ph != ph_q) tk = 0;
    ph_q = ph;
  end

  // =====================================================================
  // clock and main sequence
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    rstn_i = 1'b0;
    rd_i = 1'b0;
    wr_i = 1'b0;
    adr = 4'h0;
    be = 4'hF;
    wd = 32'h0000_0000;
    ph_q = 3'h0;
    since = 0;
    repeat (12) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd(atc_pkg::CTRL0_OFFSET, {16'h0000, atc_pkg::CTRL0_RESET});
    rd(4'h2, atc_pkg::UNMAPPED_READ);
    bus(1'b1, atc_pkg::CTRL0_OFFSET, 32'hFFFF_FFFF);
    rd(atc_pkg::CTRL0_OFFSET, 32'h0000_00FF);
    be <= 4'h0;
    bus(1'b1, atc_pkg::CTRL0_OFFSET, 32'h0000_0000);
    be <= 4'hF;
    rd(atc_pkg::CTRL0_OFFSET, 32'h0000_00FF);
    $display("register test done");
    for (int i = 0; i < 8; i++) conv(i[0], i[2:1], (i == 7) ? 5'h1F : 5'(i * 4));
    stop_test(1'b0);
  end
endmodule
`default_nettype wire
